/* core/sac_cfg.svh */
// How it works
// [RULE_01] amplifier config writes pulse amplifier stage reset
// [RULE_02] channel or reference change pulses input switch
// [RULE_03] start bit write begins a conversion
// [RULE_04] host waits oversampling-ratio samples before start
// [RULE_05] no wait needed when amplifiers bypassed
// [RULE_06] summed elementary conversions give filter notches
// [RULE_07] host clears enables of unused stages
// [RULE_08] host disables all stages when idle
// [RULE_09] host sets both bias fields to 11; t_recom writes 01 to both
// [RULE_10] host keeps third amplifier stage enabled
// [RULE_11] control register: start, count, oversampling, continuous
// [RULE_12] channel register: selector 5:1, reference bit 0
// [RULE_13] four enable bits switch converter and stages
// [RULE_14] channel selector picks positive and negative inputs
// [RULE_15] ratio two^(code+3), count two^code
// [RULE_16] result low and high bytes read-only
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define SAC_ADDR_OUT_LO 8'h50
`define SAC_ADDR_OUT_HI 8'h51
`define SAC_ADDR_CFG0 8'h52
`define SAC_ADDR_CFG1 8'h53
`define SAC_ADDR_CFG2 8'h54
`define SAC_ADDR_CFG3 8'h55
`define SAC_ADDR_CFG4 8'h56
`define SAC_ADDR_CFG5 8'h57

// ****************************************
// reset values
// ****************************************
`define SAC_RST_CFG0 8'h00
`define SAC_RST_CFG1 8'hF0
`define SAC_RST_CFG2 8'h00
`define SAC_RST_CFG3 8'h0C
`define SAC_RST_CFG4 8'h00
`define SAC_RST_CFG5 8'h00

// ****************************************
// field positions
// ****************************************
`define SAC_CFG0_START 7
`define SAC_CFG0_ELEM_CONV_COUNT_CODE_HI 6
`define SAC_CFG0_ELEM_CONV_COUNT_CODE_LO 5
`define SAC_CFG0_OSR_HI 4
`define SAC_CFG0_OSR_LO 2
`define SAC_CFG0_CONTINUOUS_CONVERSION 1
`define SAC_CFG1_ADC_BIAS_HI 7
`define SAC_CFG1_ADC_BIAS_LO 6
`define SAC_CFG1_AMP_BIAS_HI 5
`define SAC_CFG1_AMP_BIAS_LO 4
`define SAC_CFG1_EN_HI 3
`define SAC_CFG1_EN_LO 0
`define SAC_CFG2_FIN_HI 7
`define SAC_CFG2_FIN_LO 6
`define SAC_CFG2_G2_HI 5
`define SAC_CFG2_G2_LO 4
`define SAC_CFG2_OFS2_HI 3
`define SAC_CFG2_OFS2_LO 0
`define SAC_CFG3_G1 7
`define SAC_CFG3_G3_HI 6
`define SAC_CFG3_G3_LO 0
`define SAC_CFG4_OFS3_HI 6
`define SAC_CFG4_OFS3_LO 0
`define SAC_CFG5_BUSY 7
`define SAC_CFG5_DEF 6
`define SAC_CFG5_INPUT_CHANNEL_SELECTOR_HI 5
`define SAC_CFG5_INPUT_CHANNEL_SELECTOR_LO 1
`define SAC_CFG5_REFERENCE_SOURCE_SELECTOR 0
`define SAC_CFG5_WR_MASK 8'h7F

// ****************************************
// timing
// ****************************************
`define SAC_CLK_HZ 100_000_000
`define SAC_FS_MAX_HZ 500_000
`define SAC_SAMP_DIV_BASE 12'(`SAC_CLK_HZ / `SAC_FS_MAX_HZ)
`define SAC_OSR_CODE_BIAS 3
`define SAC_RESULT_BITS 16

`endif

/* core/sac_pkg.sv */
package sac_pkg;

  typedef enum logic {st_idle, st_run} sac_state_type;

  typedef struct packed {
    logic run;
    logic [13:0] acc;
    logic [9:0] samp_cnt;
    logic [2:0] elem_cnt;
    logic done;
    logic [15:0] result;
  } sac_integ_type;

  typedef struct packed {
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    logic [7:0] cfg5;
    logic mod_s1;
    logic mod_s2;
    logic [11:0] div_cnt;
    logic samp_tick;
    sac_state_type state;
    logic go;
    logic amp_rst;
    logic mux_sw;
    logic [7:0] rd_data;
  } sac_main_type;

endpackage

/* core/sac_integrator.sv */
`timescale 1ns/1ps
`include "sac_cfg.svh"

module sac_integrator (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic go,
  input wire logic samp_tick,
  input wire logic mod_bit,
  input wire logic [2:0] osr_code,
  input wire logic [1:0] elem_conv_count_code_code,
  output logic done,
  output logic [15:0] result
);

  sac_pkg::sac_integ_type q;
  sac_pkg::sac_integ_type d;
  logic [9:0] osr_last;
  logic [2:0] elem_last;
  logic [4:0] shift;
  logic [29:0] wide;

  // ****************************************
  // count limits and scaling
  // ****************************************
  // shift amount kept four bits wide so codes 5 to 7 do not wrap
  assign osr_last = 10'((11'd1 << (4'(osr_code) + 4'(`SAC_OSR_CODE_BIAS))) - 11'd1); // RULE_15
  assign elem_last = 3'((4'd1 << elem_conv_count_code_code) - 4'd1); // RULE_15
  assign shift = 5'(`SAC_RESULT_BITS) - 5'(osr_code) - 5'(`SAC_OSR_CODE_BIAS) - 5'(elem_conv_count_code_code);

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    wide = {16'h0000, q.acc} << shift;
    if (go)
    begin
      d.run = 1'b1;
      d.acc = 14'h0000;
      d.samp_cnt = 10'h000;
      d.elem_cnt = 3'h0;
    end
    else if (q.run && samp_tick)
    begin
      // elementary conversions summed back to back
      d.acc = q.acc + 14'(mod_bit); // RULE_06
      d.samp_cnt = q.samp_cnt + 10'h001;
      if (q.samp_cnt == osr_last)
      begin
        d.samp_cnt = 10'h000;
        d.elem_cnt = q.elem_cnt + 3'h1;
        if (q.elem_cnt == elem_last)
        begin
          d.run = 1'b0;
          d.done = 1'b1;
          wide = {16'h0000, d.acc} << shift;
          // all-ones input saturates at full scale
          d.result = (wide[29:16] != 14'h0000) ? 16'hFFFF : wide[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign done = q.done;
  assign result = q.result;

endmodule

/* core/sac_conv_ctrl.sv */
`timescale 1ns/1ps
`include "sac_cfg.svh"

module sac_conv_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic mod_bit,
  output logic samp_tick,
  output logic amp_reset,
  output logic input_switch,
  output logic [3:0] stage_enable,
  output logic [1:0] amplifier_bias_select,
  output logic [1:0] converter_bias_select,
  output logic [1:0] sampling_frequency_select,
  output logic first_stage_gain,
  output logic [1:0] second_stage_gain,
  output logic [3:0] second_stage_offset,
  output logic [6:0] third_stage_gain,
  output logic [6:0] third_stage_offset,
  output logic [4:0] input_channel_selector,
  output logic reference_source_selector,
  output logic default_config_select,
  output logic busy,
  output logic conv_done
);

  sac_pkg::sac_main_type q;
  sac_pkg::sac_main_type d;
  logic eng_done;
  logic [15:0] eng_result;
  logic [2:0] oversampling_code;
  logic [1:0] elem_conv_count_code;
  logic continuous_conversion;
  logic [11:0] div_last;
  logic cfg5_busy;

  // ****************************************
  // field views
  // ****************************************
  assign oversampling_code = q.cfg0[`SAC_CFG0_OSR_HI:`SAC_CFG0_OSR_LO]; // RULE_11
  assign elem_conv_count_code = q.cfg0[`SAC_CFG0_ELEM_CONV_COUNT_CODE_HI:`SAC_CFG0_ELEM_CONV_COUNT_CODE_LO]; // RULE_11
  assign continuous_conversion = q.cfg0[`SAC_CFG0_CONTINUOUS_CONVERSION]; // RULE_11
  assign div_last = 12'((`SAC_SAMP_DIV_BASE << sampling_frequency_select) - 12'd1);
  assign cfg5_busy = (q.state == sac_pkg::st_run);

  always_comb
  begin
    d = q;
    d.go = 1'b0;
    d.amp_rst = 1'b0;
    d.mux_sw = 1'b0;
    d.samp_tick = 1'b0;

    // modulator bit passes two flops first
    d.mod_s1 = mod_bit;
    d.mod_s2 = q.mod_s1;

    // sampling clock from the system clock
    if (q.div_cnt >= div_last)
    begin
      d.div_cnt = 12'h000;
      d.samp_tick = 1'b1;
    end
    else
    begin
      d.div_cnt = q.div_cnt + 12'h001;
    end

    // ****************************************
    // register writes
    // ****************************************
    if (reg_wr)
    begin
      if (reg_addr == `SAC_ADDR_CFG0)
      begin
        d.cfg0 = reg_wdata & 8'hFE;
        if (reg_wdata[`SAC_CFG0_START] && (q.state == sac_pkg::st_idle))
        begin
          d.go = 1'b1; // RULE_03
          d.state = sac_pkg::st_run;
        end
        else if (q.state == sac_pkg::st_run)
        begin
          // start stays set while a conversion runs
          d.cfg0[`SAC_CFG0_START] = 1'b1;
        end
      end
      else if (reg_addr == `SAC_ADDR_CFG1)
      begin
        d.cfg1 = reg_wdata; // RULE_13
        d.amp_rst = 1'b1; // RULE_01
      end
      else if (reg_addr == `SAC_ADDR_CFG2)
      begin
        d.cfg2 = reg_wdata;
        d.amp_rst = 1'b1; // RULE_01
      end
      else if (reg_addr == `SAC_ADDR_CFG3)
      begin
        d.cfg3 = reg_wdata;
        d.amp_rst = 1'b1; // RULE_01
      end
      else if (reg_addr == `SAC_ADDR_CFG4)
      begin
        d.cfg4 = reg_wdata & 8'h7F;
        d.amp_rst = 1'b1; // RULE_01
      end
      else if (reg_addr == `SAC_ADDR_CFG5)
      begin
        d.cfg5 = reg_wdata & `SAC_CFG5_WR_MASK; // RULE_12
        d.amp_rst = 1'b1; // RULE_01
        if (reg_wdata[`SAC_CFG5_INPUT_CHANNEL_SELECTOR_HI:`SAC_CFG5_REFERENCE_SOURCE_SELECTOR] != q.cfg5[`SAC_CFG5_INPUT_CHANNEL_SELECTOR_HI:`SAC_CFG5_REFERENCE_SOURCE_SELECTOR])
        begin
          d.mux_sw = 1'b1; // RULE_02
        end
      end
    end

    // ****************************************
    // conversion sequencing
    // ****************************************
    case (q.state)
      sac_pkg::st_idle:
      begin
      end
      sac_pkg::st_run:
      begin
        if (eng_done)
        begin
          if (continuous_conversion)
          begin
            d.go = 1'b1;
          end
          else
          begin
            d.state = sac_pkg::st_idle;
            d.cfg0[`SAC_CFG0_START] = 1'b0;
          end
        end
      end
      default:
      begin
        d.state = sac_pkg::st_idle;
      end
    endcase

    // ****************************************
    // registered read data
    // ****************************************
    if (reg_addr == `SAC_ADDR_OUT_LO)
    begin
      d.rd_data = eng_result[7:0]; // RULE_16
    end
    else if (reg_addr == `SAC_ADDR_OUT_HI)
    begin
      d.rd_data = eng_result[15:8]; // RULE_16
    end
    else if (reg_addr == `SAC_ADDR_CFG0)
    begin
      d.rd_data = q.cfg0;
    end
    else if (reg_addr == `SAC_ADDR_CFG1)
    begin
      d.rd_data = q.cfg1;
    end
    else if (reg_addr == `SAC_ADDR_CFG2)
    begin
      d.rd_data = q.cfg2;
    end
    else if (reg_addr == `SAC_ADDR_CFG3)
    begin
      d.rd_data = q.cfg3;
    end
    else if (reg_addr == `SAC_ADDR_CFG4)
    begin
      d.rd_data = q.cfg4;
    end
    else if (reg_addr == `SAC_ADDR_CFG5)
    begin
      d.rd_data = {cfg5_busy, q.cfg5[6:0]};
    end
    else
    begin
      d.rd_data = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q.cfg0 <= `SAC_RST_CFG0;
      q.cfg1 <= `SAC_RST_CFG1;
      q.cfg2 <= `SAC_RST_CFG2;
      q.cfg3 <= `SAC_RST_CFG3;
      q.cfg4 <= `SAC_RST_CFG4;
      q.cfg5 <= `SAC_RST_CFG5;
      q.mod_s1 <= 1'b0;
      q.mod_s2 <= 1'b0;
      q.div_cnt <= 12'h000;
      q.samp_tick <= 1'b0;
      q.state <= sac_pkg::st_idle;
      q.go <= 1'b0;
      q.amp_rst <= 1'b0;
      q.mux_sw <= 1'b0;
      q.rd_data <= 8'h00;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  // ****************************************
  // decimating integrator
  // ****************************************
  sac_integrator u_integ (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .go(q.go),
    .samp_tick(q.samp_tick),
    .mod_bit(q.mod_s2),
    .osr_code(oversampling_code),
    .elem_conv_count_code_code(elem_conv_count_code),
    .done(eng_done),
    .result(eng_result)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = q.rd_data;
  assign samp_tick = q.samp_tick;
  assign amp_reset = q.amp_rst;
  assign input_switch = q.mux_sw;
  assign stage_enable = q.cfg1[`SAC_CFG1_EN_HI:`SAC_CFG1_EN_LO]; // RULE_13
  assign converter_bias_select = q.cfg1[`SAC_CFG1_ADC_BIAS_HI:`SAC_CFG1_ADC_BIAS_LO];
  assign amplifier_bias_select = q.cfg1[`SAC_CFG1_AMP_BIAS_HI:`SAC_CFG1_AMP_BIAS_LO];
  assign sampling_frequency_select = q.cfg2[`SAC_CFG2_FIN_HI:`SAC_CFG2_FIN_LO];
  assign second_stage_gain = q.cfg2[`SAC_CFG2_G2_HI:`SAC_CFG2_G2_LO];
  assign second_stage_offset = q.cfg2[`SAC_CFG2_OFS2_HI:`SAC_CFG2_OFS2_LO];
  assign first_stage_gain = q.cfg3[`SAC_CFG3_G1];
  assign third_stage_gain = q.cfg3[`SAC_CFG3_G3_HI:`SAC_CFG3_G3_LO];
  assign third_stage_offset = q.cfg4[`SAC_CFG4_OFS3_HI:`SAC_CFG4_OFS3_LO];
  assign input_channel_selector = q.cfg5[`SAC_CFG5_INPUT_CHANNEL_SELECTOR_HI:`SAC_CFG5_INPUT_CHANNEL_SELECTOR_LO]; // RULE_14
  assign reference_source_selector = q.cfg5[`SAC_CFG5_REFERENCE_SOURCE_SELECTOR]; // RULE_12
  assign default_config_select = q.cfg5[`SAC_CFG5_DEF];
  assign busy = cfg5_busy;
  assign conv_done = eng_done;

endmodule

/* sim/sac_conv_ctrl_properties.sv */
`timescale 1ns/1ps
module sac_conv_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic samp_tick,
  input wire logic amp_reset,
  input wire logic input_switch,
  input wire logic [3:0] stage_enable,
  input wire logic [4:0] input_channel_selector,
  input wire logic reference_source_selector,
  input wire logic busy,
  input wire logic conv_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  amp_pulse_a: assert property (ce && reg_wr && reg_addr >= 8'h53 && reg_addr <= 8'h57 |-> ##[1:2] amp_reset)
    else $error("no amplifier reset after config write");
  amp_cause_a: assert property (amp_reset |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("amplifier reset without a write");
  sw_pulse_a: assert property (ce && reg_wr && reg_addr == 8'h57 &&
    reg_wdata[5:0] != {input_channel_selector, reference_source_selector} |-> ##[1:2] input_switch)
    else $error("no input switch after selector change");
  sw_cause_a: assert property (input_switch |-> $past(reg_addr) == 8'h57 || $past(reg_addr, 2) == 8'h57)
    else $error("input switch without selector write");
  start_busy_a: assert property (ce && reg_wr && reg_addr == 8'h52 && reg_wdata[7] |-> ##[1:2] busy)
    else $error("start bit did not begin conversion");
  enable_map_a: assert property (ce && reg_wr && reg_addr == 8'h53 |=> stage_enable == $past(reg_wdata[3:0]))
    else $error("stage enables not taken from write");
  chan_map_a: assert property (ce && reg_wr && reg_addr == 8'h57 |=>
    {input_channel_selector, reference_source_selector} == $past(reg_wdata[5:0]))
    else $error("selector not taken from write");
  busy_bit_a: assert property (ce && reg_addr == 8'h57 |=> reg_rdata[7] == $past(busy))
    else $error("busy bit readback wrong");
  ctl_bit0_a: assert property (ce && reg_addr == 8'h52 |=> !reg_rdata[0])
    else $error("control bit 0 not zero");
  done_once_a: assert property (conv_done |=> !conv_done)
    else $error("done pulse longer than one cycle");
  tick_gap_a: assert property (samp_tick |=> !samp_tick [*8])
    else $error("sampling ticks too close");
endmodule

bind sac_conv_ctrl sac_conv_props sac_conv_props_i (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .samp_tick(samp_tick),
  .amp_reset(amp_reset), .input_switch(input_switch), .stage_enable(stage_enable),
  .input_channel_selector(input_channel_selector), .reference_source_selector(reference_source_selector),
  .busy(busy), .conv_done(conv_done));

/* sim/sac_host_model.sv */
`timescale 1ns/1ps
module sac_host_model (
  input wire logic clk,
  input wire logic samp_tick,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // one-cycle strobe; data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk iff samp_tick === 1'b1);
  endtask
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic mod_bit = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, lo;
  logic reg_wr, samp_tick, amp_reset, input_switch, busy, conv_done, ref_sel;
  logic [3:0] stage_enable;
  logic [4:0] chan_sel;
  int err_total = 0;
  int n_checks = 0;
  int amp_n = 0;
  int sw_n = 0;
  int tk_n = 0;

  always #5 clk = ~clk;

  sac_conv_ctrl sac_conv_ctrl_i (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mod_bit(mod_bit), .samp_tick(samp_tick),
    .amp_reset(amp_reset), .input_switch(input_switch), .stage_enable(stage_enable),
    .amplifier_bias_select(), .converter_bias_select(), .sampling_frequency_select(),
    .first_stage_gain(), .second_stage_gain(), .second_stage_offset(), .third_stage_gain(),
    .third_stage_offset(), .input_channel_selector(chan_sel), .reference_source_selector(ref_sel),
    .default_config_select(), .busy(busy), .conv_done(conv_done));

  sac_host_model sac_host_model_i (.clk(clk), .samp_tick(samp_tick), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));

  always @(posedge clk)
  begin
    amp_n <= amp_n + (amp_reset === 1'b1);
    sw_n <= sw_n + (input_switch === 1'b1);
    tk_n <= tk_n + (samp_tick === 1'b1 && busy === 1'b1);
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] e [8] = '{8'h00, 8'h00, 8'h00, 8'hf0, 8'h00, 8'h0c, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      sac_host_model_i.rd(8'h50 + 8'(i), rv);
      chk("reset value", {8'h00, e[i]}, {8'h00, rv});
    end
    $display("test reset done");
  endtask

  task automatic t_switch;
    int a, s;
    a = amp_n;
    s = sw_n;
    sac_host_model_i.wr(8'h57, 8'h02);
    sac_host_model_i.wr(8'h57, 8'h02);
    sac_host_model_i.wr(8'h57, 8'h03);
    sac_host_model_i.wr(8'h52, 8'h00);
    sac_host_model_i.wr(8'h53, 8'hff);
    repeat (4) @(posedge clk);
    chk("amp reset count", 16'h0004, 16'(amp_n - a));
    chk("switch count", 16'h0002, 16'(sw_n - s));
    chk("selector", 16'h0003, {10'h000, chan_sel, ref_sel});
    chk("stage enable", 16'h000f, {12'h000, stage_enable});
    $display("test switch done");
  endtask

  task automatic wait_done(output int k);
    @(posedge clk);
    k = 0;
    while (conv_done !== 1'b1 && k < 8000)
    begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic t_conv(input logic [7:0] c, input logic m, input logic [15:0] e);
    int n, k, t0;
    n = (8 << c[4:2]) << c[6:5];
    mod_bit <= m;
    sac_host_model_i.settle(8 << c[4:2]);
    t0 = tk_n;
    sac_host_model_i.wr(8'h52, c);
    sac_host_model_i.wr(8'h52, c);
    sac_host_model_i.rd(8'h57, rv);
    chk("busy flag", 16'h0001, {15'h0000, rv[7]});
    k = 0;
    while (conv_done !== 1'b1 && k < 8000)
    begin
      @(posedge clk);
      k++;
    end
    chk("finished", 16'h0001, {15'h0000, k < 8000});
    chk("tick count", 16'h0001, {15'h0000, (tk_n - t0) >= n && (tk_n - t0) <= n + 1});
    sac_host_model_i.rd(8'h50, lo);
    sac_host_model_i.rd(8'h51, rv);
    chk("result", e, {rv, lo});
    sac_host_model_i.rd(8'h57, rv);
    chk("busy clear", 16'h0000, {15'h0000, rv[7]});
    $display("test conversion done");
  endtask

  task automatic t_continuous_conversion;
    int k;
    sac_host_model_i.wr(8'h53, 8'hf1);
    sac_host_model_i.wr(8'h52, 8'h82);
    wait_done(k);
    chk("first done", 16'h0001, {15'h0000, k < 8000});
    repeat (2) @(posedge clk);
    chk("continuous busy", 16'h0001, {15'h0000, busy});
    sac_host_model_i.wr(8'h52, 8'h00);
    sac_host_model_i.rd(8'h52, rv);
    chk("start held", 16'h0080, {8'h00, rv});
    wait_done(k);
    chk("last done", 16'h0001, {15'h0000, k < 8000});
    repeat (2) @(posedge clk);
    chk("continuous end", 16'h0000, {15'h0000, busy});
    sac_host_model_i.wr(8'h53, 8'hf0);
    repeat (2) @(posedge clk);
    chk("idle enables", 16'h0000, {12'h000, stage_enable});
    $display("test continuous done");
  endtask

  task automatic t_unmapped;
    sac_host_model_i.wr(8'h58, 8'hff);
    sac_host_model_i.rd(8'h58, rv);
    chk("unmapped", 16'h0000, {8'h00, rv});
    sac_host_model_i.wr(8'h50, 8'hff);
    sac_host_model_i.rd(8'h50, rv);
    chk("result low", 16'h0000, {8'h00, rv});
    $display("test unmapped done");
  endtask

  task automatic t_recom;
    logic [7:0] v [6] = '{8'h3a, 8'h59, 8'h80, 8'h0c, 8'h00, 8'h02};
    for (int i = 0; i < 6; i++)
      sac_host_model_i.wr(8'h52 + 8'(i), v[i]);
    for (int i = 0; i < 6; i++)
    begin
      sac_host_model_i.rd(8'h52 + 8'(i), rv);
      chk("recommended", {8'h00, v[i]}, {8'h00, rv});
    end
    chk("stage enable", 16'h0009, {12'h000, stage_enable});
    $display("test recommended done");
  endtask

  initial
  begin
    #400_000;
    err_total++;
    close_out;
  end

  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_switch;
    t_conv(8'h80, 1'b1, 16'hffff);
    t_conv(8'ha0, 1'b0, 16'h0000);
    t_continuous_conversion;
    t_unmapped;
    t_recom;
    close_out;
  end
endmodule
